// >>> shared/ees_pkg.sv
package ees_pkg;
	// clock and program timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int PROG_TIME_MS  = 5;
	// longest time, so integer division rounds down
	localparam int PROG_CYCLES   = PROG_TIME_MS * (CLK_HZ / 1000);
	localparam int TMR_W         = 17;

	// array geometry
	localparam int ADDR_W        = 11;
	localparam int DATA_W        = 8;
	localparam int PAGE_AW       = 4;
	localparam int PAGE_BYTES    = 16;
	localparam int BLK_W         = 3;

	// values after reset, bits per byte and default type code
	localparam logic [ADDR_W-1:0] ADDR_RST    = 11'h000;
	localparam logic [DATA_W-1:0] ERASED_VAL  = 8'hFF;
	localparam logic [3:0]        BIT_CNT_RST = 4'h0;
	localparam logic [3:0]        BITS_BYTE   = 4'h8;
	// arbitrary value, not a real part code
	localparam logic [3:0]        DEV_CODE_DEF = 4'h5;

	// address word field positions
	localparam int AW_CODE_HI = 7;
	localparam int AW_CODE_LO = 4;
	localparam int AW_BLK_HI  = 3;
	localparam int AW_BLK_LO  = 1;
	localparam int AW_DIR     = 0;

	// protocol states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX   = 6'h02,
		ST_ACK  = 6'h04,
		ST_TX   = 6'h08,
		ST_MACK = 6'h10,
		ST_PROG = 6'h20
	} ees_state_t;

	// which byte of a write is being received
	typedef enum logic [2:0] {
		PH_DEV  = 3'h1,
		PH_WORD = 3'h2,
		PH_DATA = 3'h4
	} ees_phase_t;

	// line events seen on the sampled two-wire bus
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} ees_bus_ev_t;

	// page commit from buffer into the array
	typedef struct packed {
		logic                                 en;
		logic [ADDR_W-PAGE_AW-1:0]            page;
		logic [PAGE_BYTES-1:0]                mask;
		logic [PAGE_BYTES-1:0][DATA_W-1:0]    data;
	} ees_commit_t;
endpackage

// >>> core/ees_sync.sv
`timescale 1ns/10ps
module ees_sync #(
	parameter int         W       = 2,
	parameter logic [1:0] RST_VAL = 2'h3
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// asynchronous levels in, synchronised out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// two stages; only the second stage is visible outside
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= RST_VAL[W-1:0];
			q       <= RST_VAL[W-1:0];
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// >>> core/ees_mem.sv
`timescale 1ns/10ps
module ees_mem #(
	parameter int AW = ees_pkg::ADDR_W,
	parameter int DW = ees_pkg::DATA_W,
	parameter int PW = ees_pkg::PAGE_AW
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// read port, combinational
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data,
	// page program port
	input  ees_pkg::ees_commit_t commit
);
	logic [DW-1:0] mem_ff [2**AW];

	assign rd_data = mem_ff[rd_addr];

	// reset models a fresh erased array; masked page bytes land in one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_ff[i] <= ees_pkg::ERASED_VAL;
			end
		end else if (commit.en) begin
			for (int j = 0; j < 2**PW; j++) begin
				if (commit.mask[j]) begin
					mem_ff[{commit.page, PW'(j)}] <= commit.data[j];
				end
			end
		end
	end
endmodule

// >>> core/ees_slave.sv
// Behaviour
// [RL1] stop is data rising while clock high.
// [RL2] stop during a read returns to standby.
// [RL3] stop in a write starts programming; standby after program time.
// [RL4] data is sampled on each rising clock edge.
// [RL5] master keeps data steady around each rising clock edge.
// [RL6] receiver of each byte drives a low acknowledge.
// [RL7] address word: type code, three block bits, direction bit.
// [RL8] eighth bit one means read, zero means write.
// [RL9] matching code acknowledged on ninth clock; mismatch goes to standby.
// [RL10] byte write: acknowledge low address byte, then one data byte.
// [RL11] during internal programming all bus input is ignored.
// [RL12] further data bytes collect into one sixteen byte page.
// [RL13] only four low address bits increment, wrapping within the page.
// [RL14] no acknowledge to write address word while programming.
// [RL15] address counter holds last accessed address plus one.
// [RL16] read shifts out counter byte; nack and stop give standby.
// [RL17] read wraps at top to zero; write wraps within page.
// [RL18] address counter cleared to zero at power-up.
// [RL19] random read uses dummy write then repeated start and read.
// [RL20] master acknowledge low advances address and sends next byte.
// [RL21] interface reset is start, nine released clocks, start.
// [RL22] interface reset has no effect while programming.
// [RL23] start is data falling while clock high.
// [RL24] outgoing bits change on falling clock edges.
// [RL25] write protect high blocks programming; reads still allowed.
// [RL26] program time is a parameter; busy held until it expires.
`timescale 1ns/10ps
module ees_slave #(
	parameter int         PROG_CYCLES = ees_pkg::PROG_CYCLES,
	parameter logic [3:0] DEV_CODE    = ees_pkg::DEV_CODE_DEF
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// two-wire bus pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// write protect pin
	input  wire logic wp_in,
	// internal program cycle running
	output logic      prog_busy
);
	localparam int AW = ees_pkg::ADDR_W;
	localparam int DW = ees_pkg::DATA_W;
	localparam int PW = ees_pkg::PAGE_AW;
	localparam int NB = ees_pkg::PAGE_BYTES;

	ees_pkg::ees_state_t  state_ff;
	ees_pkg::ees_state_t  after_ack_ff;
	ees_pkg::ees_phase_t  phase_ff;
	ees_pkg::ees_bus_ev_t ev;
	ees_pkg::ees_commit_t commit;

	logic [2:0]                   pin_q;
	logic                         scl_q;
	logic                         sda_q;
	logic                         wp_q;
	logic                         scl_prev_ff;
	logic                         sda_prev_ff;
	logic [3:0]                   bit_cnt_ff;
	logic [DW-1:0]                rx_sh_ff;
	logic [DW-1:0]                tx_sh_ff;
	logic [ees_pkg::BLK_W-1:0]    blk_ff;
	logic [AW-1:0]                addr_ff;
	logic                         mack_ff;
	logic                         sda_oe_ff;
	logic [ees_pkg::TMR_W-1:0]    tmr_ff;
	logic                         busy_ff;
	logic [NB-1:0]                pg_mask_ff;
	logic [NB-1:0][DW-1:0]        pg_data_ff;
	logic [AW-PW-1:0]             pg_ff;
	logic [DW-1:0]                rd_data;
	logic                         byte_done;
	logic                         code_ok;
	logic                         load_tx;
	logic                         prog_go;
	logic                         tmr_done;

	// pins cross into mclk through two flops each
	ees_sync #(
		.W       (3),
		.RST_VAL (2'h3)
	) u_sync (
		.clk (mclk),
		.rst (sys_rst),
		.d   ({wp_in, sda_in, scl_in}),
		.q   (pin_q)
	);

	assign scl_q = pin_q[0];
	assign sda_q = pin_q[1];
	assign wp_q  = pin_q[2];

	// previous sampled levels for edge finding
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl_q;
			sda_prev_ff <= sda_q;
		end
	end

	// bus conditions; data edges count only while clock stays high
	assign ev.start = scl_q & scl_prev_ff & sda_prev_ff & ~sda_q;  // see [RL23]
	assign ev.stop  = scl_q & scl_prev_ff & ~sda_prev_ff & sda_q;  // see [RL1]
	assign ev.rise  = scl_q & ~scl_prev_ff;
	assign ev.fall  = ~scl_q & scl_prev_ff;

	// decode helpers
	assign byte_done = (state_ff == ees_pkg::ST_RX) && ev.fall && (bit_cnt_ff == ees_pkg::BITS_BYTE);
	assign code_ok   = (rx_sh_ff[ees_pkg::AW_CODE_HI:ees_pkg::AW_CODE_LO] == DEV_CODE);
	assign load_tx   = ev.fall &&
		(((state_ff == ees_pkg::ST_ACK) && (after_ack_ff == ees_pkg::ST_TX)) ||
		((state_ff == ees_pkg::ST_MACK) && !mack_ff));  // see [RL20]
	// programming only when bytes were taken and protect is low
	assign prog_go   = ev.stop && (state_ff != ees_pkg::ST_PROG) &&
		(phase_ff == ees_pkg::PH_DATA) && (|pg_mask_ff) && !wp_q;  // see [RL3] [RL25]
	assign tmr_done  = busy_ff && (tmr_ff == '0);

	// protocol sequencer and data pin drive
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_ff     <= ees_pkg::ST_IDLE;
			after_ack_ff <= ees_pkg::ST_IDLE;
			phase_ff     <= ees_pkg::PH_DEV;
			bit_cnt_ff   <= ees_pkg::BIT_CNT_RST;
			rx_sh_ff     <= 8'h00;
			tx_sh_ff     <= 8'h00;
			blk_ff       <= 3'h0;
			mack_ff      <= 1'b1;
			sda_oe_ff    <= 1'b0;
		end else if (state_ff == ees_pkg::ST_PROG) begin
			// deaf to starts, stops and reset clocks until done
			sda_oe_ff <= 1'b0;  // see [RL11] [RL14] [RL22]
			if (tmr_done) begin
				state_ff <= ees_pkg::ST_IDLE;  // see [RL3]
			end
		end else if (ev.start) begin
			// a repeated start also ends a dummy write; see [RL19] [RL21]
			state_ff   <= ees_pkg::ST_RX;
			phase_ff   <= ees_pkg::PH_DEV;
			bit_cnt_ff <= ees_pkg::BIT_CNT_RST;
			sda_oe_ff  <= 1'b0;
		end else if (ev.stop) begin
			sda_oe_ff <= 1'b0;
			phase_ff  <= ees_pkg::PH_DEV;
			state_ff  <= prog_go ? ees_pkg::ST_PROG : ees_pkg::ST_IDLE;  // see [RL2] [RL3]
		end else begin
			case (state_ff)
				ees_pkg::ST_RX: begin
					if (ev.rise) begin
						rx_sh_ff   <= {rx_sh_ff[DW-2:0], sda_q};  // see [RL4] [RL5]
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (byte_done) begin
						bit_cnt_ff <= ees_pkg::BIT_CNT_RST;
						if (phase_ff == ees_pkg::PH_DEV) begin
							if (code_ok) begin
								// ack driven low through the ninth clock; see [RL6] [RL9]
								blk_ff    <= rx_sh_ff[ees_pkg::AW_BLK_HI:ees_pkg::AW_BLK_LO];
								sda_oe_ff <= 1'b1;
								state_ff  <= ees_pkg::ST_ACK;
								// see [RL7] [RL8]
								after_ack_ff <= rx_sh_ff[ees_pkg::AW_DIR] ?
									ees_pkg::ST_TX : ees_pkg::ST_RX;
								phase_ff  <= ees_pkg::PH_WORD;
							end else begin
								state_ff <= ees_pkg::ST_IDLE;  // see [RL9]
							end
						end else begin
							// word address then data bytes; see [RL10] [RL12]
							sda_oe_ff    <= 1'b1;
							state_ff     <= ees_pkg::ST_ACK;
							after_ack_ff <= ees_pkg::ST_RX;
							phase_ff     <= ees_pkg::PH_DATA;
						end
					end
				end
				ees_pkg::ST_ACK: begin
					if (ev.fall) begin
						bit_cnt_ff <= ees_pkg::BIT_CNT_RST;
						state_ff   <= after_ack_ff;
						if (after_ack_ff == ees_pkg::ST_TX) begin
							tx_sh_ff  <= rd_data;  // see [RL16]
							sda_oe_ff <= ~rd_data[DW-1];  // see [RL24]
						end else begin
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ees_pkg::ST_TX: begin
					if (ev.rise) begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (ev.fall) begin
						if (bit_cnt_ff == ees_pkg::BITS_BYTE) begin
							// let the master drive its acknowledge
							sda_oe_ff  <= 1'b0;
							bit_cnt_ff <= ees_pkg::BIT_CNT_RST;
							state_ff   <= ees_pkg::ST_MACK;
						end else begin
							tx_sh_ff  <= {tx_sh_ff[DW-2:0], 1'b0};
							sda_oe_ff <= ~tx_sh_ff[DW-2];  // see [RL24]
						end
					end
				end
				ees_pkg::ST_MACK: begin
					if (ev.rise) begin
						mack_ff <= sda_q;  // see [RL6]
					end else if (load_tx) begin
						tx_sh_ff  <= rd_data;  // see [RL20]
						sda_oe_ff <= ~rd_data[DW-1];
						state_ff  <= ees_pkg::ST_TX;
					end else if (ev.fall) begin
						// nack: stay released and wait for the stop
						state_ff <= ees_pkg::ST_IDLE;  // see [RL16]
					end
				end
				default: begin
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// address counter: word load, page step on writes, full step on reads
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_ff <= ees_pkg::ADDR_RST;  // see [RL18]
		end else if (state_ff == ees_pkg::ST_PROG) begin
			addr_ff <= addr_ff;
		end else if (load_tx) begin
			// counter ends one past the byte sent; wraps to zero at top
			addr_ff <= addr_ff + 11'h001;  // see [RL15] [RL17] [RL20]
		end else if (byte_done && (phase_ff == ees_pkg::PH_WORD)) begin
			addr_ff <= {blk_ff, rx_sh_ff};  // see [RL10] [RL19]
		end else if (byte_done && (phase_ff == ees_pkg::PH_DATA)) begin
			// only the low nibble moves, so the page is never left
			addr_ff[PW-1:0] <= addr_ff[PW-1:0] + 4'h1;  // see [RL13] [RL17]
		end
	end

	// page buffer; an address seen twice keeps only the newest byte
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pg_mask_ff <= '0;
			pg_ff      <= '0;
		end else if (tmr_done || (ev.start && (state_ff != ees_pkg::ST_PROG))) begin
			pg_mask_ff <= '0;
		end else if (byte_done && (phase_ff == ees_pkg::PH_WORD)) begin
			pg_ff <= {blk_ff, rx_sh_ff[DW-1:PW]};
		end else if (byte_done && (phase_ff == ees_pkg::PH_DATA)) begin
			pg_mask_ff[addr_ff[PW-1:0]] <= 1'b1;  // see [RL12] [RL13]
		end
	end

	generate
		for (genvar g = 0; g < NB; g++) begin : g_pg
			// byte lanes of the page buffer
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					pg_data_ff[g] <= ees_pkg::ERASED_VAL;
				end else if (byte_done && (phase_ff == ees_pkg::PH_DATA) &&
					(addr_ff[PW-1:0] == PW'(g))) begin
					pg_data_ff[g] <= rx_sh_ff;  // see [RL13]
				end
			end
		end
	endgenerate

	// program timer; length is a parameter so benches can shorten it
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_ff <= 1'b0;
			tmr_ff  <= '0;
		end else if (prog_go) begin
			busy_ff <= 1'b1;
			tmr_ff  <= ees_pkg::TMR_W'(PROG_CYCLES - 1);  // see [RL26]
		end else if (tmr_done) begin
			busy_ff <= 1'b0;  // see [RL26]
		end else if (busy_ff) begin
			tmr_ff <= tmr_ff - 17'h00001;
		end
	end

	// commit lands when the timer expires; array looks unchanged until then
	assign commit.en   = tmr_done;
	assign commit.page = pg_ff;
	assign commit.mask = pg_mask_ff;
	assign commit.data = pg_data_ff;

	ees_mem #(
		.AW (AW),
		.DW (DW),
		.PW (PW)
	) u_mem (
		.clk     (mclk),
		.rst     (sys_rst),
		.rd_addr (addr_ff),
		.rd_data (rd_data),
		.commit  (commit)
	);

	// open-drain: only ever drive low
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sda_out   <= 1'b0;
			prog_busy <= 1'b0;
		end else begin
			sda_out   <= 1'b0;
			prog_busy <= busy_ff;
		end
	end

	assign sda_oe = sda_oe_ff;
endmodule

// >>> bench/ees_slave_asserts.sv
`timescale 1ns/10ps
module ees_slave_asserts #(
	parameter int PROG_CYCLES = 400
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// two-wire pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic sda_out,
	input  wire logic sda_oe,
	// write protect and busy
	input  wire logic wp_in,
	input  wire logic prog_busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	int busy_cnt_ff;

	// length of the current busy stretch, to cap the program timer
	always_ff @(posedge mclk) begin
		if (sys_rst || !prog_busy)
			busy_cnt_ff <= 0;
		else
			busy_cnt_ff <= busy_cnt_ff + 1;
	end

	// clock seen high long enough for the slave to know it
	sequence scl_held;
		scl_in[*4];
	endsequence
	// busy held at least eight cycles; the bench timer gives 400
	sequence busy_run;
		prog_busy[*8];
	endsequence

	chk_oe_pulls_low: assert property (sda_oe |-> !sda_out)
		else $error("data pin driven high");
	chk_busy_no_ack: assert property (prog_busy |-> !sda_oe)
		else $error("data pin pulled while programming");
	chk_busy_holds: assert property ($rose(prog_busy) |-> busy_run)
		else $error("busy dropped too early");
	chk_busy_bound: assert property (busy_cnt_ff <= PROG_CYCLES + 4)
		else $error("busy outlived the program timer");
	chk_oe_scl_high: assert property (scl_held |=> $stable(sda_oe))
		else $error("output moved while clock high");
	chk_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
		else $error("output moved without a clock fall");
	chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=> !sda_oe && !prog_busy)
		else $error("outputs active after reset");
	chk_wp_blocks: assert property ($rose(prog_busy) |-> !wp_in || !$past(wp_in, 8))
		else $error("programming while protected");
	chk_ack_stands: assert property ($rose(sda_oe) |-> sda_oe[*6])
		else $error("pulled low for too short a time");
endmodule

bind ees_slave ees_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
	.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .prog_busy(prog_busy)
);

// >>> bench/ees_master.sv
`timescale 1ns/10ps
module ees_master (
	// system clock, pacing only
	input  wire logic mclk,
	// bus lines; sda_rel high lets the pull-up win
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda_wire
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// one clock period, 4 mclk low then 4 high; data moves mid-low only
	task automatic bit_x(input logic v, output logic s);
		scl <= 1'b0;
		tk(2);
		sda_rel <= v;
		tk(2);
		scl <= 1'b1;
		tk(2);
		s = sda_wire;
		tk(2);
	endtask

	// start is cond(1,0), stop is cond(0,1): data moves while clock high
	task automatic cond(input logic first, input logic last);
		scl <= 1'b0;
		tk(2);
		sda_rel <= first;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_rel <= last;
		tk(4);
	endtask

	// msb first, then the slave's acknowledge is sampled
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, ack);
	endtask

	// mack low asks for the next byte
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(mack, s);
	endtask

	// start, nine released clocks, start; leaves the bus after a start
	task automatic sw_reset();
		logic s;
		cond(1'b1, 1'b0);
		repeat (9) bit_x(1'b1, s);
		cond(1'b1, 1'b0);
	endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int         PROG  = 400;
	localparam logic [3:0] DCODE = 4'h6; // arbitrary type code

	logic mclk, sys_rst, wp_in, sda_out, sda_oe, prog_busy, scl, sda_rel, sda_wire;
	int   miscompares, tests_run;

	// open-drain line with pull-up: low when anyone pulls
	assign sda_wire = sda_rel & ~(sda_oe & ~sda_out);

	ees_slave #(.PROG_CYCLES(PROG), .DEV_CODE(DCODE)) dut_u (
		.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .prog_busy(prog_busy));
	ees_master mst_u (.mclk(mclk), .scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask

	// bounded wait for the busy level
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (prog_busy !== v && n < PROG + 100) begin
			@(posedge mclk);
			n++;
		end
		chk(8'(prog_busy), 8'(v));
	endtask

	function automatic logic [7:0] aw(input logic [2:0] blk, input logic rd);
		return {DCODE, blk, rd};
	endfunction

	// start, write address word, word address; both acked
	task automatic point(input logic [10:0] a);
		logic k;
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(a[10:8], 1'b0), k);
		chk(8'(k), 8'h00);
		mst_u.wr_byte(a[7:0], k);
		chk(8'(k), 8'h00);
	endtask

	// 18 bytes from near page end, polled, then read back
	task automatic t_page();
		logic       k;
		logic [7:0] d;
		point(11'h32E);
		for (int i = 0; i < 18; i++) begin
			mst_u.wr_byte(8'h40 + 8'(i), k);
			chk(8'(k), 8'h00);
		end
		mst_u.cond(1'b0, 1'b1);
		wait_busy(1'b1);
		mst_u.sw_reset();
		mst_u.wr_byte(aw(3'h3, 1'b0), k);
		chk(8'(k), 8'h01);
		mst_u.cond(1'b0, 1'b1);
		wait_busy(1'b0);
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(3'h3, 1'b0), k);
		chk(8'(k), 8'h00);
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(3'h3, 1'b1), k);
		mst_u.rd_byte(1'b1, d);
		chk(d, 8'h42);
		mst_u.cond(1'b0, 1'b1);
		point(11'h320);
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(3'h3, 1'b1), k);
		for (int n = 0; n < 16; n++) begin
			mst_u.rd_byte(n == 15, d);
			chk(d, n > 13 ? 8'h50 + 8'(n - 14) : 8'h42 + 8'(n));
		end
		mst_u.cond(1'b0, 1'b1);
	endtask

	// read across the top address back to zero
	task automatic t_top();
		logic       k;
		logic [7:0] d;
		point(11'h000);
		mst_u.wr_byte(8'h3C, k);
		mst_u.cond(1'b0, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		point(11'h7FF);
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(3'h7, 1'b1), k);
		mst_u.rd_byte(1'b0, d);
		chk(d, 8'hFF);
		mst_u.rd_byte(1'b1, d);
		chk(d, 8'h3C);
		mst_u.cond(1'b0, 1'b1);
	endtask

	// protected write is acked but never programmed
	task automatic t_wp();
		logic       k;
		logic [7:0] d;
		wp_in <= 1'b1;
		point(11'h100);
		mst_u.wr_byte(8'h77, k);
		mst_u.cond(1'b0, 1'b1);
		repeat (20) @(posedge mclk);
		chk(8'(prog_busy), 8'h00);
		wp_in <= 1'b0;
		point(11'h100);
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte(aw(3'h1, 1'b1), k);
		mst_u.rd_byte(1'b1, d);
		chk(d, 8'hFF);
		mst_u.cond(1'b0, 1'b1);
	endtask

	// foreign type code, then a reset in mid-command
	task automatic t_mis();
		logic       k;
		logic [7:0] d;
		mst_u.cond(1'b1, 1'b0);
		mst_u.wr_byte({~DCODE, 4'h0}, k);
		chk(8'(k), 8'h01);
		mst_u.cond(1'b0, 1'b1);
		point(11'h055);
		mst_u.sw_reset();
		mst_u.wr_byte(aw(3'h0, 1'b1), k);
		chk(8'(k), 8'h00);
		mst_u.rd_byte(1'b1, d);
		chk(d, 8'hFF);
		mst_u.cond(1'b0, 1'b1);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		wp_in = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_page();
		t_top();
		t_wp();
		t_mis();
		wrap_up();
	end

	// hang guard, well past the expected run length
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end
endmodule
